// ===== rca_ctrl.sv
/*
 * Relay command access controller: per-port access levels, password
 * attempts, alarm pulse, calendar, display selection and the action
 * pulses of the serial command set, plus automatic message routing.
 * Assumes every input comes from logic on the same clock: a front end
 * that parses serial text and a time code decoder.
 */
// Functional notes
// - Level one password; third failure pulses alarm.
// - Level two entry from level one or two always pulses alarm.
// - Quit drops to level zero, targets view.
// - Breaker reset clears counters, stamps time.
// - Date sets/displays; alarm when year changes.
// - Time code overrides; sync command forces attempt.
// - Event index 1..12, 1 newest.
// - History lists twelve newest events.
// - Target selector 0..8, optional repeat.
// - Target reset clears latches, selector zero.
// - Trigger captures record, manual trigger type.
// - Demand and peak resets are independent.
// - Meter repeats output count times.
// - Show group 1..6, no modification.
// - Auto setting routes to port 1/2/both.
// - Auto messages need selected, untimed-out port.
// - Time sets/displays; time code wins.
// - Port timeouts 0..30 min, defaults 15/0.
`timescale 1ns/1ps
`include "rca_defines.svh"

module rca_ctrl
	import rca_pkg::*;
#(
	parameter int unsigned ONE_SEC_CYC = `RCA_ONE_SEC_CYC
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Parsed command from the serial front end.
	input wire logic i_cmd_valid,
	input wire rca_cmd_t i_cmd,
	// Configuration.
	input wire logic i_pw_en,
	input wire logic [1:0] i_auto_sel,
	// Port activity and time code.
	input wire logic [1:0] i_rx_act,
	input wire logic i_tc_valid,
	input wire rca_stamp_t i_tc,
	// Replies and actions.
	output rca_reply_t o_reply,
	output rca_act_t o_act,
	output rca_evt_t o_cap_type,
	// Status.
	output logic [1:0][1:0] o_level,
	output logic [3:0] o_tar_sel,
	output logic o_alarm,
	output logic [1:0] o_auto_en,
	output rca_stamp_t o_now,
	output rca_stamp_t o_brk_stamp,
	output logic [1:0][4:0] o_limit
);

	// ==========================================================
	// Helpers
	localparam logic [26:0] SEC_LAST = 27'(ONE_SEC_CYC - 1);
	localparam logic [26:0] SEC_CNT = 27'(ONE_SEC_CYC);

	function automatic logic in_rng(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		in_rng = (v >= lo) && (v <= hi);
	endfunction : in_rng

	// Least level each command needs; quit and access work anywhere.
	function automatic logic [1:0] need_lvl(input rca_op_t op);
		case (op)
		op_access: need_lvl = 2'h0;
		op_quit: need_lvl = 2'h0;
		op_set_timeout: need_lvl = 2'h2;
		default: need_lvl = 2'h1;
		endcase
	endfunction : need_lvl

	function automatic rca_stamp_t tod_step(input rca_stamp_t t);
		tod_step = t;
		if (t.second != 6'h3B) begin
			tod_step.second = t.second + 6'h01;
		end else begin
			tod_step.second = 6'h00;
			if (t.minute != 6'h3B) begin
				tod_step.minute = t.minute + 6'h01;
			end else begin
				tod_step.minute = 6'h00;
				tod_step.hour = (t.hour == 5'h17) ? 5'h00 : t.hour + 5'h01;
			end
		end
	endfunction : tod_step

	// ==========================================================
	// State
	rca_state_t s_q;
	rca_state_t s_d;
	logic sec_tick;
	logic min_tick;
	logic alarm_go;
	logic pidx;
	logic [1:0] plvl;
	logic [7:0] narg;

	always_comb begin
		s_d = s_q;
		s_d.act = '0;
		s_d.reply.valid = 1'b0;
		alarm_go = 1'b0;
		pidx = i_cmd.port;
		plvl = s_q.lvl[i_cmd.port];
		narg = 8'h00;
		sec_tick = (s_q.presc == SEC_LAST);
		min_tick = sec_tick &&
			(s_q.sec_in_min == (`RCA_SEC_PER_MIN - 6'h01));
		s_d.presc = sec_tick ? 27'h0 : s_q.presc + 27'h1;
		if (sec_tick) begin
			s_d.sec_in_min = min_tick ? 6'h00 : s_q.sec_in_min + 6'h01;
			s_d.now = tod_step(s_q.now);
		end
		// Idle time is counted in whole minutes of the shared minute
		// tick, so expiry can come up to one minute early.
		for (int p = 0; p < 2; p++) begin
			if (i_rx_act[p]) begin
				s_d.idle[p] = 5'h00;
				s_d.susp[p] = 1'b0;
			end else if (min_tick && s_q.limit[p] != 5'h00 &&
				!s_q.susp[p]) begin
				if (s_q.idle[p] + 5'h01 >= s_q.limit[p]) begin
					s_d.lvl[p] = 2'h0;
					s_d.susp[p] = 1'b1;
					s_d.fails[p] = 2'h0;
				end else begin
					s_d.idle[p] = s_q.idle[p] + 5'h01;
				end
			end
		end
		// ==========================================================
		// Command execution
		if (i_cmd_valid) begin
			s_d.reply.valid = 1'b1;
			s_d.reply.port = i_cmd.port;
			s_d.reply.op = i_cmd.op;
			s_d.reply.st = st_ok;
			s_d.reply.arg = 8'h00;
			s_d.reply.cnt = 8'h00;
			if (plvl < need_lvl(i_cmd.op)) begin
				s_d.reply.st = st_denied;
			end else begin
				case (i_cmd.op)
				op_access: begin
					if (plvl == 2'h0) begin
						if (!i_pw_en || i_cmd.pw_ok) begin
							s_d.lvl[pidx] = 2'h1;
							s_d.fails[pidx] = 2'h0;
						end else begin
							s_d.reply.st = st_denied;
							if (s_q.fails[pidx] + 2'h1 == `RCA_FAIL_LIM) begin
								alarm_go = 1'b1;
								s_d.fails[pidx] = 2'h0;
							end else begin
								s_d.fails[pidx] = s_q.fails[pidx] + 2'h1;
							end
						end
					end
				end
				enter_level_two_cmd: begin
					alarm_go = 1'b1;
					if (!i_pw_en || i_cmd.pw_ok) begin
						s_d.lvl[pidx] = 2'h2;
					end else begin
						s_d.reply.st = st_denied;
					end
				end
				op_quit: begin
					s_d.lvl[pidx] = 2'h0;
					s_d.tar_sel = 4'h0;
				end
				op_breaker_reset: begin
					s_d.act.brk_clr = 1'b1;
					s_d.brk_stamp = s_q.now;
				end
				op_date: begin
					if (!i_cmd.has_arg) begin
						s_d.reply.st = st_ok;
					end else if (in_rng(i_cmd.a, 8'h01, `RCA_MONTH_MAX) &&
						in_rng(i_cmd.b, 8'h01, `RCA_DAY_MAX) &&
						i_cmd.c < 8'h64) begin
						s_d.now.month = i_cmd.a[3:0];
						s_d.now.day = i_cmd.b[4:0];
						s_d.now.year = i_cmd.c[6:0];
						alarm_go = (i_cmd.c[6:0] != s_q.now.year);
					end else begin
						s_d.reply.st = st_bad_arg;
					end
				end
				op_time: begin
					if (!i_cmd.has_arg) begin
						s_d.reply.st = st_ok;
					end else if (i_cmd.a <= `RCA_HOUR_MAX &&
						i_cmd.b <= `RCA_MINSEC_MAX &&
						i_cmd.c <= `RCA_MINSEC_MAX) begin
						s_d.now.hour = i_cmd.a[4:0];
						s_d.now.minute = i_cmd.b[5:0];
						s_d.now.second = i_cmd.c[5:0];
					end else begin
						s_d.reply.st = st_bad_arg;
					end
				end
				op_sync: s_d.act.sync_req = 1'b1;
				op_event: begin
					narg = i_cmd.has_arg ? i_cmd.a : 8'h01;
					if (in_rng(narg, 8'h01, `RCA_EVT_MAX)) begin
						s_d.reply.arg = narg - 8'h01;
					end else begin
						s_d.reply.st = st_bad_arg;
					end
				end
				op_history: s_d.reply.cnt = `RCA_HIST_CNT;
				op_target: begin
					narg = i_cmd.has_arg ? i_cmd.a : 8'h00;
					if (narg <= `RCA_TAR_MAX) begin
						s_d.tar_sel = narg[3:0];
						s_d.reply.arg = narg;
						s_d.reply.cnt = (i_cmd.b == 8'h00) ?
							8'h01 : i_cmd.b;
					end else begin
						s_d.reply.st = st_bad_arg;
					end
				end
				op_target_reset: begin
					s_d.act.tar_clr = 1'b1;
					s_d.tar_sel = 4'h0;
				end
				op_trigger: s_d.act.capture = 1'b1;
				demand_reset_option: s_d.act.dem_clr = 1'b1;
				peak_demand_reset_option: s_d.act.peak_clr = 1'b1;
				op_meter: begin
					s_d.reply.cnt = (i_cmd.has_arg && i_cmd.a != 8'h00) ?
						i_cmd.a : 8'h01;
				end
				show_group_settings_cmd: begin
					if (in_rng(i_cmd.a, 8'h01, `RCA_GRP_MAX)) begin
						s_d.reply.arg = i_cmd.a;
					end else begin
						s_d.reply.st = st_bad_arg;
					end
				end
				op_set_timeout: begin
					if (i_cmd.a <= `RCA_TO_MAX) begin
						s_d.limit[i_cmd.b[0]] = i_cmd.a[4:0];
						s_d.idle[i_cmd.b[0]] = 5'h00;
					end else begin
						s_d.reply.st = st_bad_arg;
					end
				end
				default: s_d.reply.st = st_bad_arg;
				endcase
			end
		end
		// Time code is applied last so that it beats a manual entry
		// made in the same cycle; the year is kept.
		if (i_tc_valid) begin
			s_d.now.month = i_tc.month;
			s_d.now.day = i_tc.day;
			s_d.now.hour = i_tc.hour;
			s_d.now.minute = i_tc.minute;
			s_d.now.second = i_tc.second;
		end
		if (alarm_go) begin
			s_d.alarm_cnt = SEC_CNT;
		end else if (s_q.alarm_cnt != 27'h0) begin
			s_d.alarm_cnt = s_q.alarm_cnt - 27'h1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
			s_q.limit[0] <= `RCA_TO_P1_DEF;
			s_q.limit[1] <= `RCA_TO_P2_DEF;
			s_q.now.month <= 4'h1;
			s_q.now.day <= 5'h01;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs
	assign o_reply = s_q.reply;
	assign o_act = s_q.act;
	assign o_cap_type = manual_trigger_event_type;
	assign o_level = s_q.lvl;
	assign o_tar_sel = s_q.tar_sel;
	assign o_alarm = (s_q.alarm_cnt != 27'h0);
	assign o_now = s_q.now;
	assign o_brk_stamp = s_q.brk_stamp;
	assign o_limit = s_q.limit;
	// Level is deliberately not checked: event summaries go out at
	// any access level.
	assign o_auto_en[0] = (i_auto_sel == `RCA_AUTO_P1 ||
		i_auto_sel == `RCA_AUTO_BOTH) && !s_q.susp[0];
	assign o_auto_en[1] = (i_auto_sel == `RCA_AUTO_P2 ||
		i_auto_sel == `RCA_AUTO_BOTH) && !s_q.susp[1];

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	third_fail_alarm_a: assert property (
		i_cmd_valid && i_cmd.op == op_access && i_pw_en &&
		!i_cmd.pw_ok && s_q.lvl[i_cmd.port] == 2'h0 &&
		s_q.fails[i_cmd.port] == 2'h2 |=> o_alarm && o_reply.st == st_denied)
		else $error("third failed access gave no alarm");
	level_two_alarm_a: assert property (
		i_cmd_valid && i_cmd.op == enter_level_two_cmd &&
		s_q.lvl[i_cmd.port] != 2'h0 |=> s_q.alarm_cnt == SEC_CNT)
		else $error("level two entry gave no one second alarm");
	quit_level_a: assert property (
		i_cmd_valid && i_cmd.op == op_quit |=>
		o_level[$past(i_cmd.port)] == 2'h0 && o_tar_sel == 4'h0)
		else $error("quit did not drop level and targets");
	brk_stamp_a: assert property (
		i_cmd_valid && i_cmd.op == op_breaker_reset &&
		s_q.lvl[i_cmd.port] != 2'h0 |=>
		o_act.brk_clr && o_brk_stamp == $past(o_now))
		else $error("breaker reset missing clear or stamp");
	tc_override_a: assert property (
		i_tc_valid |=> o_now.month == $past(i_tc.month) &&
		o_now.second == $past(i_tc.second))
		else $error("time code did not override clock");
	event_index_a: assert property (
		i_cmd_valid && i_cmd.op == op_event && i_cmd.has_arg &&
		s_q.lvl[i_cmd.port] != 2'h0 && i_cmd.a == 8'h0C |=>
		o_reply.st == st_ok && o_reply.arg == 8'h0B)
		else $error("event twelve not mapped to oldest");
	tar_reset_a: assert property (
		o_act.tar_clr |-> o_tar_sel == 4'h0 && $past(i_cmd_valid))
		else $error("target reset left selector set");
	meter_reset_sep_a: assert property (
		i_cmd_valid && i_cmd.op == demand_reset_option &&
		s_q.lvl[i_cmd.port] != 2'h0 |=> o_act.dem_clr && !o_act.peak_clr)
		else $error("demand reset touched peak values");
	auto_route_a: assert property (
		o_auto_en[1] |-> i_auto_sel[1] && !s_q.susp[1])
		else $error("auto message routed to wrong port");
	alarm_hold_a: assert property (
		$rose(o_alarm) |-> s_q.alarm_cnt == SEC_CNT ##1
		s_q.alarm_cnt == SEC_CNT - 27'h1)
		else $error("alarm pulse length wrong");

	level_two_cov: cover property (
		i_cmd_valid && i_cmd.op == enter_level_two_cmd ##1
		o_reply.st == st_ok);
	timeout_cov: cover property ($rose(s_q.susp[0]));
	trigger_cov: cover property (o_act.capture);
	both_ports_cov: cover property (o_auto_en == 2'h3);

endmodule : rca_ctrl

// ===== rca_ctrl_tb.sv
/*
 * Self-checking bench of the command access controller.
 * Assumes a one second count of 100 cycles; a minute is 6000 cycles.
 */
`timescale 1ns/1ps

module rca_ctrl_tb
	import rca_pkg::*;
();
	localparam int unsigned SEC = 100;
	logic i_clk, i_rst, i_cmd_valid, i_pw_en, i_tc_valid, o_alarm;
	logic [1:0] i_auto_sel, i_rx_act, o_auto_en;
	logic [1:0][1:0] o_level;
	logic [1:0][4:0] o_limit;
	logic [3:0] o_tar_sel;
	rca_cmd_t i_cmd;
	rca_stamp_t i_tc, o_now, o_brk_stamp;
	rca_reply_t o_reply;
	rca_act_t o_act;
	rca_evt_t o_cap_type;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	// Calendar as it stood while the last command was being taken.
	rca_stamp_t now_seen;

	rca_ctrl #(.ONE_SEC_CYC(SEC)) dut_u (.i_clk(i_clk), .i_rst(i_rst),
		.i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_pw_en(i_pw_en),
		.i_auto_sel(i_auto_sel), .i_rx_act(i_rx_act),
		.i_tc_valid(i_tc_valid), .i_tc(i_tc), .o_reply(o_reply),
		.o_act(o_act), .o_cap_type(o_cap_type), .o_level(o_level),
		.o_tar_sel(o_tar_sel), .o_alarm(o_alarm), .o_auto_en(o_auto_en),
		.o_now(o_now), .o_brk_stamp(o_brk_stamp), .o_limit(o_limit));
	rca_term term_u (.i_clk(i_clk), .o_cmd_valid(i_cmd_valid),
		.o_cmd(i_cmd), .o_rx_act(i_rx_act));

	// ==========================================================
	// Clock, watchdog and reporting.
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		now_seen <= o_now;
	end
	// The timeout scenario alone may need up to one minute of idle time.
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			final_report();
		end
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report
	task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask : chk_v
	task automatic chk_r(input rca_status_t st);
		chk_v(8'({o_reply.valid, o_reply.st}), 8'({1'b1, st}));
	endtask : chk_r
	// Counts the cycles that the alarm contact stays closed.
	task automatic chk_alarm(input logic on);
		int n;
		n = 0;
		while (o_alarm === 1'b1 && n < 200) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		chk_v(8'(n), on ? 8'(SEC) : 8'h00);
	endtask : chk_alarm
	task automatic q(input rca_op_t op, input logic ha, input logic [7:0] a,
		input logic [7:0] b, input rca_status_t st);
		term_u.send(1'b0, op, ha, 1'b1, a, b, 8'h00);
		chk_r(st);
	endtask : q

	// ==========================================================
	// Scenarios.
	task automatic t_reset;
		chk_v(8'(o_limit[0]), 8'h0F);
		chk_v(8'(o_limit[1]), 8'h00);
		chk_v(8'(o_level), 8'h00);
		chk_v(8'({o_now.month, o_now.day}), 8'h21);
	endtask : t_reset
	task automatic t_access;
		for (int i = 0; i < 3; i++) begin
			term_u.send(1'b0, op_access, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
			chk_r(st_denied);
			chk_alarm(i == 2);
		end
		term_u.send(1'b0, op_access, 1'b0, 1'b1, 8'h00, 8'h00, 8'h00);
		chk_v(8'(o_level[0]), 8'h01);
	endtask : t_access
	task automatic t_level2;
		term_u.send(1'b1, enter_level_two_cmd, 1'b0, 1'b1, 8'h00, 8'h00,
			8'h00);
		chk_r(st_denied);
		chk_v(8'(o_reply.port), 8'h01);
		chk_alarm(1'b0);
		term_u.send(1'b0, enter_level_two_cmd, 1'b0, 1'b0, 8'h00, 8'h00,
			8'h00);
		chk_r(st_denied);
		chk_alarm(1'b1);
		q(enter_level_two_cmd, 1'b0, 8'h00, 8'h00, st_ok);
		chk_v(8'(o_level[0]), 8'h02);
		chk_alarm(1'b1);
	endtask : t_level2
	task automatic t_args;
		q(op_event, 1'b1, 8'h0C, 8'h00, st_ok);
		chk_v(o_reply.arg, 8'h0B);
		q(op_event, 1'b0, 8'h00, 8'h00, st_ok);
		chk_v(o_reply.arg, 8'h00);
		q(op_event, 1'b1, 8'h0D, 8'h00, st_bad_arg);
		q(op_history, 1'b0, 8'h00, 8'h00, st_ok);
		chk_v(o_reply.cnt, 8'h0C);
		q(op_meter, 1'b1, 8'h03, 8'h00, st_ok);
		chk_v(o_reply.cnt, 8'h03);
		q(show_group_settings_cmd, 1'b1, 8'h06, 8'h00, st_ok);
		chk_v(o_reply.arg, 8'h06);
		q(show_group_settings_cmd, 1'b1, 8'h07, 8'h00, st_bad_arg);
		q(op_target, 1'b1, 8'h08, 8'h02, st_ok);
		chk_v(o_reply.cnt, 8'h02);
		q(op_target, 1'b1, 8'h09, 8'h00, st_bad_arg);
		chk_v(8'(o_tar_sel), 8'h08);
	endtask : t_args
	task automatic t_quit;
		@(posedge i_clk);
		i_pw_en <= 1'b0;
		q(op_quit, 1'b0, 8'h00, 8'h00, st_ok);
		chk_v(8'({o_level[0], o_tar_sel}), 8'h00);
		q(op_trigger, 1'b0, 8'h00, 8'h00, st_denied);
		chk_v(8'(o_act), 8'h00);
		term_u.send(1'b0, op_access, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
		chk_v(8'(o_level[0]), 8'h01);
		@(posedge i_clk);
		i_pw_en <= 1'b1;
		q(op_target, 1'b1, 8'h04, 8'h00, st_ok);
	endtask : t_quit
	task automatic t_act;
		rca_op_t ops[6];
		ops = '{op_breaker_reset, op_target_reset, op_trigger,
			demand_reset_option, peak_demand_reset_option, op_sync};
		for (int i = 0; i < 6; i++) begin
			q(ops[i], 1'b0, 8'h00, 8'h00, st_ok);
			chk_v(8'(o_act), 8'(6'h20 >> i));
			if (i == 0) chk_v(8'(o_brk_stamp === now_seen), 8'h01);
		end
		chk_v(8'(o_cap_type), 8'(manual_trigger_event_type));
		chk_v(8'(o_tar_sel), 8'h00);
	endtask : t_act
	task automatic t_date;
		term_u.send(1'b0, op_date, 1'b1, 1'b1, 8'h06, 8'h01, 8'h00);
		chk_alarm(1'b0);
		term_u.send(1'b0, op_date, 1'b1, 1'b1, 8'h06, 8'h01, 8'h5C);
		chk_alarm(1'b1);
		q(op_date, 1'b0, 8'h00, 8'h00, st_ok);
		chk_v(8'(o_now.year), 8'h5C);
		q(op_date, 1'b1, 8'h0D, 8'h01, st_bad_arg);
		q(op_time, 1'b1, 8'h0D, 8'h20, st_ok);
		chk_v(8'({o_now.hour, o_now.month}), 8'({5'h0D, 4'h6}));
		q(op_time, 1'b1, 8'h18, 8'h00, st_bad_arg);
		fork
			q(op_time, 1'b1, 8'h0A, 8'h00, st_ok);
			begin
				@(posedge i_clk);
				i_tc <= '{4'h3, 5'h04, 7'h00, 5'h07, 6'h00, 6'h00};
				i_tc_valid <= 1'b1;
				@(posedge i_clk);
				i_tc_valid <= 1'b0;
			end
		join
		chk_v(8'({o_now.hour, o_now.month}), 8'({5'h07, 4'h3}));
		chk_v(8'(o_now.day), 8'h04);
	endtask : t_date
	task automatic t_auto;
		int n;
		for (int s = 0; s < 4; s++) begin
			@(posedge i_clk);
			i_auto_sel <= 2'(s);
			@(posedge i_clk);
			#1;
			chk_v(8'(o_auto_en), 8'(s));
		end
		q(enter_level_two_cmd, 1'b0, 8'h00, 8'h00, st_ok);
		q(op_set_timeout, 1'b1, 8'h1F, 8'h00, st_bad_arg);
		q(op_set_timeout, 1'b1, 8'h01, 8'h00, st_ok);
		chk_v(8'(o_limit[0]), 8'h01);
		n = 0;
		while (o_level[0] !== 2'h0 && n < 13000) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		chk_v(8'(o_level[0]), 8'h00);
		chk_v(8'(o_auto_en), 8'h02);
		term_u.pulse(2'h1);
		chk_v(8'(o_auto_en), 8'h03);
	endtask : t_auto

	initial begin
		i_rst = 1'b1;
		i_pw_en = 1'b1;
		i_auto_sel = 2'h3;
		i_tc_valid = 1'b0;
		i_tc = '0;
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		#1;
		t_reset();
		t_access();
		t_level2();
		t_args();
		t_quit();
		t_act();
		t_date();
		t_auto();
		final_report();
	end
endmodule : rca_ctrl_tb

// ===== rca_defines.svh
/*
 * Constants of the relay command access controller: limits, defaults,
 * field ranges and timing counts.
 * Assumes a single 100 MHz clock; included by its bare name.
 */
`ifndef RCA_DEFINES_SVH
`define RCA_DEFINES_SVH
`define RCA_CLK_NS 10
`define RCA_ONE_SEC_NS 1000000000
`define RCA_ONE_SEC_CYC (`RCA_ONE_SEC_NS / `RCA_CLK_NS)
`define RCA_SEC_PER_MIN 6'h3C
`define RCA_TO_P1_DEF 5'h0F
`define RCA_TO_P2_DEF 5'h00
`define RCA_TO_MAX 8'h1E
`define RCA_FAIL_LIM 2'h3
`define RCA_EVT_MAX 8'h0C
`define RCA_HIST_CNT 8'h0C
`define RCA_GRP_MAX 8'h06
`define RCA_TAR_MAX 8'h08
`define RCA_MONTH_MAX 8'h0C
`define RCA_DAY_MAX 8'h1F
`define RCA_HOUR_MAX 8'h17
`define RCA_MINSEC_MAX 8'h3B
`define RCA_AUTO_P1 2'h1
`define RCA_AUTO_P2 2'h2
`define RCA_AUTO_BOTH 2'h3
`endif

// ===== rca_pkg.sv
/*
 * Types of the relay command access controller: command codes, decoded
 * command, calendar stamp, reply, action pulses and the module state.
 * Assumes commands arrive already parsed by a serial front end.
 */
package rca_pkg;
	typedef enum logic [4:0] {
		op_access = 5'h01,
		enter_level_two_cmd = 5'h02,
		op_quit = 5'h03,
		op_breaker_reset = 5'h04,
		op_date = 5'h05,
		op_time = 5'h06,
		op_sync = 5'h07,
		op_event = 5'h08,
		op_history = 5'h09,
		op_target = 5'h0A,
		op_target_reset = 5'h0B,
		op_trigger = 5'h0C,
		demand_reset_option = 5'h0D,
		peak_demand_reset_option = 5'h0E,
		op_meter = 5'h0F,
		show_group_settings_cmd = 5'h10,
		op_set_timeout = 5'h11
	} rca_op_t;
	typedef enum logic [1:0] {
		st_ok = 2'h0,
		st_denied = 2'h1,
		st_bad_arg = 2'h2
	} rca_status_t;
	typedef enum logic [1:0] {
		evt_fault = 2'h0,
		manual_trigger_event_type = 2'h1
	} rca_evt_t;
	typedef struct packed {
		logic port;
		rca_op_t op;
		logic has_arg;
		logic pw_ok;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
	} rca_cmd_t;
	typedef struct packed {
		logic [3:0] month;
		logic [4:0] day;
		logic [6:0] year;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} rca_stamp_t;
	typedef struct packed {
		logic valid;
		logic port;
		rca_op_t op;
		rca_status_t st;
		logic [7:0] arg;
		logic [7:0] cnt;
	} rca_reply_t;
	typedef struct packed {
		logic brk_clr;
		logic tar_clr;
		logic capture;
		logic dem_clr;
		logic peak_clr;
		logic sync_req;
	} rca_act_t;
	typedef struct packed {
		logic [1:0][1:0] lvl;
		logic [1:0][1:0] fails;
		logic [26:0] presc;
		logic [5:0] sec_in_min;
		logic [1:0][4:0] idle;
		logic [1:0][4:0] limit;
		logic [1:0] susp;
		logic [26:0] alarm_cnt;
		logic [3:0] tar_sel;
		rca_stamp_t now;
		rca_stamp_t brk_stamp;
		rca_reply_t reply;
		rca_act_t act;
	} rca_state_t;
endpackage : rca_pkg

// ===== rca_term.sv
/*
 * Terminal model: sends parsed commands and line activity to the
 * controller, one request per call.
 * Assumes a single caller process and the controller's clock.
 */
`timescale 1ns/1ps

module rca_term
	import rca_pkg::*;
(
	// Clock.
	input wire logic i_clk,
	// Command and activity.
	output logic o_cmd_valid,
	output rca_cmd_t o_cmd,
	output logic [1:0] o_rx_act
);
	// Port two is a monitored printer channel: it never shows activity
	// and its limit is left at zero so it never times out.
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd = '0;
		o_rx_act = 2'h0;
	end

	// Returns one ns after the edge that took the command, so the reply
	// is settled when the caller looks at it.
	task automatic send(input logic pt, input rca_op_t op, input logic ha,
		input logic pw, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] c);
		@(posedge i_clk);
		o_cmd_valid <= 1'b1;
		o_cmd <= '{pt, op, ha, pw, a, b, c};
		@(posedge i_clk);
		o_cmd_valid <= 1'b0;
		o_cmd <= ~o_cmd;
		#1;
	endtask : send

	task automatic pulse(input logic [1:0] p);
		@(posedge i_clk);
		o_rx_act <= p;
		@(posedge i_clk);
		o_rx_act <= 2'h0;
		#1;
	endtask : pulse
endmodule : rca_term
